// ---- logic/cdd_control.sv ----
`include "cdd_defines.svh"
// Function
// - The riser link carries no more than three codecs, so population is one, two or three.
// - A single riser codec moves to the next free address and data line while codec-down enable is low.
// - Two riser codecs both move to the next free addresses on a three-codec controller when the enable is low.
// - While the enable is high, riser codecs keep their primary address and data line.
// - A two-codec riser picks the strong pull-up when data line 2 is not on a three-codec controller, else weak.
// - A three-codec riser always selects the strong pull-up.
// - With the enable high, codecs on lines 0, 1 and 2 take addresses 00b, 01b and 10b or 11b.
// - With the enable low, codecs on lines 0 and 1 take 01b and 10b or 11b and the line 2 codec takes 00b.
// - Addresses and pull-up selection are settled before the link reset rises.
// - The sensed line 2 level passes through during reset and is frozen at its rising edge.
module cdd_control
    import cdd_pkg::*;
(
    input  wire logic      mclk_i,               // System clock, 200 MHz.
    input  wire logic      rst_i,                // Synchronous reset, active high.
    input  wire logic      link_reset_n_i,       // Link reset level, active low.
    input  wire logic      sdata_in2_i,          // Sensed level of data line 2.
    input  wire logic      codec_down_enable_n_i,// Sensed codec-down enable level.
    input  wire cdd_pop_t  pop_i,                // Build-time riser population strap.
    input  wire logic      alt_ter_i,            // Build-time choice of 11b for the third address.
    output logic           strong_pullup_o,      // Close the 1 kohm switch.
    output cdd_addr_t      addr0_o,              // Address of riser codec 0.
    output cdd_addr_t      addr1_o,              // Address of riser codec 1.
    output cdd_addr_t      addr2_o,              // Address of riser codec 2.
    output logic [1:0]     line0_o,              // Data line used by riser codec 0.
    output logic           locked_o              // Selection frozen, link out of reset.
);
    cdd_state_t state;
    logic       sense;
    logic       down_n;
    cdd_pop_t   pop;
    logic       alt;
    logic       in_reset;
    logic       enab_src;
    logic       next_strong;
    cdd_addr_t  next_addr0;
    cdd_addr_t  next_addr1;
    cdd_addr_t  next_addr2;
    logic [1:0] next_line0;
    // Decoded straps and the sensed line 2 level as the output logic sees them.
    logic       pop_one;
    logic       pop_two;
    logic       pop_three;
    logic       line2_src;
    cdd_pop_t   pop_strap;

    // Third address, picked once at build time.
    function automatic cdd_addr_t ter_addr(input logic a);
        ter_addr = a ? `CDD_ADDR_TER_ALT : `CDD_ADDR_TER;
    endfunction

    // The link reset is active low; the capture, the freeze and the lock all key off this decode.
    assign in_reset = ~link_reset_n_i;

    // A blank strap is read as a single codec, so the link never has to serve a fourth one.
    // Straps are captured with the sensed levels, so a rewired strap waits for the next link reset.
    assign pop_strap = (pop_i == CDD_POP_NONE_S) ? CDD_POP_ONE_S : pop_i;

    // Population decode of the captured strap, shared by the pull-up and address paths.
    assign pop_one   = (pop == CDD_POP_ONE_S);
    assign pop_two   = (pop == CDD_POP_TWO_S);
    assign pop_three = (pop == CDD_POP_THREE_S);

    // While the link is held the raw levels steer the outputs, so they are settled long
    // before the release edge; afterwards only the frozen copies are looked at.
    assign enab_src  = in_reset ? codec_down_enable_n_i : down_n;
    assign line2_src = in_reset ? sdata_in2_i : sense;

    // Strong pull-up for three codecs, or for two codecs with line 2 unclaimed (high).
    // A single codec never takes the strong pull-up; it has no third line to guard.
    assign next_strong = pop_three |
                         (pop_two & line2_src);

    // Address map of the riser slots.
    //   Enable high: line 0 at 00b, line 1 at 01b, line 2 at 10b or 11b, codec 0 on line 0.
    //   Enable low:  line 0 at 01b, line 1 at 10b or 11b, line 2 at 00b.
    // A single codec only fills slot 0, so its slot 1 stays parked at 01b when demoted.
    // The map is not sequential; the controller must cope with gaps in the addresses.
    // The third address is a build-time choice and does not follow the enable.
    assign next_addr0 = enab_src ? `CDD_ADDR_PRI : `CDD_ADDR_SEC;
    assign next_addr1 = (enab_src | pop_one) ? `CDD_ADDR_SEC : ter_addr(alt);
    assign next_addr2 = enab_src ? ter_addr(alt) : `CDD_ADDR_PRI;
    // A lone codec hops to the next data line when demoted; with two codecs on the riser
    // line 1 is already taken, so codec 0 stays on line 0 and only its address moves.
    assign next_line0 = (enab_src | ~pop_one) ? 2'h0 : 2'h1;

    // Capture straps and sensed levels at the release edge; a transparent latch is
    // replaced by a clocked capture so the design stays in one clock domain.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state  <= CDD_ST_RESET;
            sense  <= `CDD_RST_SENSE;
            down_n <= `CDD_RST_SENSE;
            pop    <= CDD_POP_NONE_S;
            alt    <= 1'b0;
        end else if (in_reset) begin
            state  <= CDD_ST_RESET;
            sense  <= sdata_in2_i;
            down_n <= codec_down_enable_n_i;
            pop    <= pop_strap;
            alt    <= alt_ter_i;
        end else begin
            state  <= CDD_ST_RUN;
        end
    end

    // Outputs are registered; they stop changing once the link is released.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            strong_pullup_o <= 1'b0;
            addr0_o         <= `CDD_ADDR_PRI;
            addr1_o         <= `CDD_ADDR_SEC;
            addr2_o         <= `CDD_ADDR_TER;
            line0_o         <= 2'h0;
        end else begin
            case (state)
                CDD_ST_RESET: begin
                    strong_pullup_o <= next_strong;
                    addr0_o         <= next_addr0;
                    addr1_o         <= next_addr1;
                    addr2_o         <= next_addr2;
                    line0_o         <= next_line0;
                end
                CDD_ST_RUN: begin
                    strong_pullup_o <= strong_pullup_o;
                end
                default: begin
                    strong_pullup_o <= 1'b0;
                end
            endcase
        end
    end

    // The selection counts as frozen from the first edge that sees the link released.
    assign locked_o = (state == CDD_ST_RUN);

    // Link held in reset at two edges in a row.
    sequence seq_link_held;
        !link_reset_n_i ##1 !link_reset_n_i;
    endsequence

    // Link held at one edge and released at the next, which is the capture point.
    sequence seq_link_release;
        !link_reset_n_i ##1 link_reset_n_i;
    endsequence

    // Selection frozen while the link is still running.
    sequence seq_locked_run;
        locked_o && link_reset_n_i;
    endsequence

    // Once locked, no output may move until the link reset falls; a glitch here would
    // move a codec while the controller is already talking to it.
    AST_HOLD_PULL: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_locked_run |=> $stable(strong_pullup_o))
        else $error("pull-up select changed while locked");
    AST_HOLD_ADDR: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_locked_run |=> $stable(addr0_o) && $stable(addr1_o) && $stable(addr2_o))
        else $error("address changed while locked");
    AST_HOLD_LINE: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_locked_run |=> $stable(line0_o))
        else $error("data line changed while locked");
    AST_LOCK_RISE: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_link_release |=> locked_o)
        else $error("selection not locked after release");
    AST_LOCK_DROP: assert property (@(posedge mclk_i) disable iff (rst_i)
        in_reset |=> !locked_o)
        else $error("selection still locked during link reset");

    // Population and pull-up selection; the strap must never leave a blank count behind,
    // and the pull-up must match the population that was captured.
    AST_POP_VALID: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o |-> pop != CDD_POP_NONE_S)
        else $error("blank population captured");
    AST_THREE_STRONG: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && pop_three |-> strong_pullup_o)
        else $error("three-codec riser without strong pull-up");
    AST_TWO_SEL: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && pop_two |-> strong_pullup_o == sense)
        else $error("two-codec pull-up select wrong");

    // Address map after capture, for both levels of the codec-down enable; the third
    // address keeps the build-time choice in both maps.
    AST_HIGH_MAP: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && down_n |-> addr0_o == 2'h0 && addr1_o == 2'h1 && line0_o == 2'h0 && addr2_o[1])
        else $error("high enable map wrong");
    AST_HIGH_ALT: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && down_n |-> addr2_o[0] == alt)
        else $error("high enable third address wrong");
    AST_LOW_MAP: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && !down_n |-> addr0_o == 2'h1 && addr2_o == 2'h0)
        else $error("low enable map wrong");
    AST_LOW_ONE_LINE: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && !down_n && pop_one |-> line0_o == 2'h1)
        else $error("lone codec not moved to the next data line");
    AST_LOW_TWO: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && !down_n && !pop_one |-> addr1_o[1] && line0_o == 2'h0)
        else $error("second codec not demoted");
    AST_LOW_ALT: assert property (@(posedge mclk_i) disable iff (rst_i)
        locked_o && !down_n && !pop_one |-> addr1_o[0] == alt)
        else $error("low enable third address wrong");

    // Capture at the release edge, and outputs that follow the raw levels while the
    // link is held, so nothing is left to settle when the codecs leave reset.
    AST_CAPTURE: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_link_release |=> sense == $past(sdata_in2_i, 2))
        else $error("line 2 level not captured at release");
    AST_DOWN_CAPTURE: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_link_release |=> down_n == $past(codec_down_enable_n_i, 2))
        else $error("enable level not captured at release");
    AST_SETTLE: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_link_held |=> strong_pullup_o == $past(next_strong))
        else $error("pull-up not settled during reset");
    AST_FOLLOW: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_link_held |=> addr0_o == ($past(codec_down_enable_n_i) ? 2'h0 : 2'h1))
        else $error("address does not follow the enable during reset");
endmodule // cdd_control

// ---- logic/cdd_defines.svh ----
`ifndef CDD_DEFINES_SVH
`define CDD_DEFINES_SVH
// Codec address codes.
`define CDD_ADDR_PRI      2'h0
`define CDD_ADDR_SEC      2'h1
`define CDD_ADDR_TER      2'h2
`define CDD_ADDR_TER_ALT  2'h3
// Riser population encodings.
`define CDD_POP_ONE       2'h1
`define CDD_POP_TWO       2'h2
`define CDD_POP_THREE     2'h3
// System reset value of the captured sensed levels.
`define CDD_RST_SENSE     1'h0
`endif

// ---- logic/cdd_pkg.sv ----
package cdd_pkg;
    typedef enum logic [1:0] {
        CDD_POP_NONE_S  = 2'b00,
        CDD_POP_ONE_S   = 2'b01,
        CDD_POP_TWO_S   = 2'b10,
        CDD_POP_THREE_S = 2'b11
    } cdd_pop_t;
    typedef logic [1:0] cdd_addr_t;
    typedef enum logic [0:0] {
        CDD_ST_RESET = 1'b0,
        CDD_ST_RUN   = 1'b1
    } cdd_state_t;
endpackage

// ---- dv/cdd_mb_model.sv ----
// Motherboard controller and codec as seen from the riser pins.
module cdd_mb_model (
    input  wire logic mclk_i,          // System clock.
    input  wire logic three_codec_i,   // Controller serves three codecs.
    input  wire logic mb_codec_i,      // Codec fitted on the motherboard.
    input  wire logic link_reset_n_i,  // Link reset, active low.
    input  wire logic strong_pullup_i, // Riser 1 kohm switch closed.
    output logic      sdata_in2_o,     // Data line 2 level.
    output logic      enab_n_o         // Codec-down enable level.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tg = 1'b0;
    // Live traffic after release toggles every cycle, so a leaky capture shows.
    always @(posedge mclk_i) tg <= ~tg;
    // Codecs float during reset, so only the controller pull-down sets the level.
    assign sdata_in2_o = link_reset_n_i ? tg : ~three_codec_i;
    // Strong pull-up disables our codec; it never moves its address.
    assign enab_n_o = strong_pullup_i | ~mb_codec_i;
endmodule // cdd_mb_model

// ---- dv/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cdd_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, link_reset_n_i = 1'b0, alt_ter_i = 1'b0;
    logic three = 1'b0, mb = 1'b1, sd2, enab_n, strong_pullup_o, locked_o;
    cdd_pop_t pop_i = CDD_POP_TWO_S;
    cdd_addr_t addr0_o, addr1_o, addr2_o;
    logic [1:0] line0_o;
    int errors = 0, tests_run = 0, cyc = 0;
    cdd_control i_cdd_control (.mclk_i(mclk_i), .rst_i(rst_i), .link_reset_n_i(link_reset_n_i),
        .sdata_in2_i(sd2), .codec_down_enable_n_i(enab_n), .pop_i(pop_i), .alt_ter_i(alt_ter_i),
        .strong_pullup_o(strong_pullup_o), .addr0_o(addr0_o), .addr1_o(addr1_o),
        .addr2_o(addr2_o), .line0_o(line0_o), .locked_o(locked_o));
    cdd_mb_model i_cdd_mb_model (.mclk_i(mclk_i), .three_codec_i(three), .mb_codec_i(mb),
        .link_reset_n_i(link_reset_n_i), .strong_pullup_i(strong_pullup_o),
        .sdata_in2_o(sd2), .enab_n_o(enab_n));
    initial forever #2.5 mclk_i = ~mclk_i;
    // A hang is cut short well past the 85 or so cycles the tests need.
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            summarize();
        end
    end
    task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    // Checks the selection during link reset, then again after release.
    task automatic step(input cdd_pop_t p, input logic thr, m, alt, exp_s, chk_s);
        logic e;
        logic o;
        logic [1:0] a1;
        pop_i <= p; three <= thr; mb <= m; alt_ter_i <= alt; link_reset_n_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        e = exp_s | ~m;
        o = (p == CDD_POP_ONE_S) || (p == CDD_POP_NONE_S);
        a1 = (e || o) ? 2'h1 : {1'b1, alt};
        for (int k = 0; k < 2; k++) begin
            #1;
            if (chk_s) cmp({1'b0, strong_pullup_o}, {1'b0, exp_s});
            cmp(addr0_o, e ? 2'h0 : 2'h1);
            cmp(addr1_o, a1);
            cmp(addr2_o, e ? {1'b1, alt} : 2'h0);
            cmp(line0_o, {1'b0, ~e & o});
            cmp({1'b0, locked_o}, {1'b0, k[0]});
            @(posedge mclk_i);
            link_reset_n_i <= 1'b1; pop_i <= CDD_POP_THREE_S; alt_ter_i <= ~alt;
            repeat (4) @(posedge mclk_i);
        end
    endtask
    task automatic t_two_on_two(); step(CDD_POP_TWO_S, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        $display("two codecs, two-codec controller done"); endtask
    task automatic t_two_on_three(); step(CDD_POP_TWO_S, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        $display("two codecs, three-codec controller done"); endtask
    task automatic t_three(); step(CDD_POP_THREE_S, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        $display("three codecs done"); endtask
    task automatic t_one(); step(CDD_POP_ONE_S, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("single codec, no motherboard codec done"); endtask
    task automatic t_one_down(); step(CDD_POP_NONE_S, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        $display("single codec demoted, blank strap done"); endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_two_on_two();
        t_two_on_three();
        t_three();
        t_one();
        t_one_down();
        summarize();
    end
endmodule // tb_top
